/* File: src/ttu_pkg.sv */
// Constants, register map and helpers for the threshold trigger unit
package ttu_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_FREQ_ON = 8'h04;
    localparam logic [7:0] ADR_FREQ_OFF = 8'h08;
    localparam logic [7:0] ADR_GATE = 8'h0C;
    localparam logic [7:0] ADR_GAIN = 8'h10;
    localparam logic [7:0] ADR_OFFSET = 8'h14;
    localparam logic [7:0] ADR_ATRIG_ON = 8'h18;
    localparam logic [7:0] ADR_ATRIG_OFF = 8'h1C;
    localparam logic [7:0] ADR_DIFF_ON = 8'h20;
    localparam logic [7:0] ADR_DIFF_DELTA = 8'h24;
    localparam logic [7:0] ADR_DECIMALS = 8'h28;
    localparam logic [7:0] ADR_STATUS = 8'h2C;
    localparam logic [7:0] ADR_MEASURED = 8'h30;
    localparam logic [7:0] ADR_WORKING = 8'h34;

    // ==========================================================
    // Control field positions
    localparam int CTRL_FREQ_EN = 0;
    localparam int CTRL_GATE_EXT = 1;
    localparam int CTRL_THR_EXT = 2;

    // ==========================================================
    // Values after reset
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam logic [15:0] FREQ_ON_RST = 16'h0000;
    localparam logic [15:0] FREQ_OFF_RST = 16'h0000;
    // 1.00 s gate, gain 1.00
    localparam logic [15:0] GATE_RST = 16'h0064;
    localparam logic [15:0] GAIN_RST = 16'h0064;
    localparam logic [15:0] SIGNED_RST = 16'h0000;
    localparam logic [1:0] DECIMALS_RST = 2'h0;

    // ==========================================================
    // Value ranges (9999, 5, 1000, 10000, 20000, 100)
    localparam int FREQ_THR_MAX = 32'h0000_270F;
    localparam int GATE_MIN = 32'h0000_0005;
    localparam int GATE_MAX = 32'h0000_270F;
    localparam int ANALOG_MAX = 32'h0000_03E8;
    localparam int GAIN_LIM = 32'h0000_03E8;
    localparam int OFFSET_LIM = 32'h0000_2710;
    localparam int THR_LIM = 32'h0000_4E20;
    localparam int GAIN_SCALE = 32'h0000_0064;

    // ==========================================================
    // Timing: gate time counts in hundredths of a second
    localparam int CLK_PERIOD_NS = 32'h0000_000A;
    localparam int GATE_UNIT_NS = 32'h0098_9680;
    localparam int GATE_UNIT_CYCLES = (GATE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic int clamp(input int v, input int lo, input int hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

endpackage

/* File: src/ttu_thresh.sv */
// Hysteresis or window threshold switch with registered output
`timescale 1ns/1ps
module ttu_thresh
    import ttu_pkg::*;
#(
    parameter int W = 21
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Evaluation
    input wire logic i_eval,
    input wire logic signed [W-1:0] i_value,
    input wire logic signed [W-1:0] i_on,
    input wire logic signed [W-1:0] i_off,
    // Result
    output logic o_q
);

    if (W < 2) begin : g_chk
        $error("ttu_thresh: W too small");
    end

    typedef struct packed {
        logic q;
    } ttu_thr_state_t;

    ttu_thr_state_t s;
    ttu_thr_state_t next_s;

    always_comb begin
        next_s = s;
        if (i_eval) begin
            if (i_on >= i_off) begin
                if (i_value > i_on) begin
                    next_s.q = 1'b1;
                end else if (i_value <= i_off) begin
                    next_s.q = 1'b0;
                end
            end else begin
                next_s.q = (i_value >= i_on) && (i_value < i_off);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    assign o_q = s.q;

endmodule

/* File: src/ttu_top.sv */
// Threshold trigger unit: frequency, analog and differential triggers
//
// Operation
// - Count rising pulse edges only
// - Frequency thresholds unsigned 0 to 9999
// - Gate time 0.05 to 99.99 seconds
// - On>=Off: high above On, low at/below Off
// - On<Off: high within [On, Off)
// - Frequency output updates once per gate
// - Measured value is pulses per gate
// - Gate and analog thresholds selectable from block
// - Working value is input times gain plus offset
// - Gain +-10.00, offset +-10000
// - Analog thresholds within +-20000
// - Analog On>=Off: hysteresis switching
// - Analog On<Off: window [On, Off)
// - Decimals setting is display only
// - Analog input held as 0 to 1000
// - Differential on and delta within +-20000
// - Differential off equals on plus delta
// - Delta sign picks hysteresis or window
`timescale 1ns/1ps
module ttu_top
    import ttu_pkg::*;
#(
    parameter int TICK_CYCLES = GATE_UNIT_CYCLES,
    parameter int CNT_W = 20
) (
    // Clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Function inputs
    input wire logic I_PULSE,
    input wire logic [9:0] I_ANALOG_OPERAND,
    input wire logic signed [15:0] I_EXT_GATE,
    input wire logic signed [15:0] I_EXT_ON,
    input wire logic signed [15:0] I_EXT_OFF,
    // Function outputs
    output logic O_FREQ_Q,
    output logic O_ATRIG_Q,
    output logic O_DIFF_Q,
    output logic [CNT_W-1:0] O_MEASURED,
    output logic signed [17:0] O_WORKING
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int CW = 21;

    // ==========================================================
    // Elaboration checks
    if (TICK_CYCLES < 1 || CNT_W < 14 || CNT_W > 20) begin : g_chk
        $error("ttu_top: TICK_CYCLES or CNT_W out of range");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [2:0] ctrl;
        logic [15:0] freq_on;
        logic [15:0] freq_off;
        logic [15:0] gate;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic signed [15:0] a_on;
        logic signed [15:0] a_off;
        logic signed [15:0] d_on;
        logic signed [15:0] d_delta;
        logic [1:0] decimals;
        logic pulse_prev;
        logic [TW-1:0] tick_cnt;
        logic [15:0] centi_cnt;
        logic [15:0] cur_gate;
        logic [CNT_W-1:0] pulse_cnt;
        logic [CNT_W-1:0] measured;
        logic freq_eval;
        logic signed [17:0] working;
    } ttu_state_t;

    ttu_state_t s;
    ttu_state_t next_s;

    logic freq_q;
    logic atrig_q;
    logic diff_q;

    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0]) begin
            m[7:0] = d[7:0];
        end
        if (sel[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction

    function automatic int as_s(input logic [15:0] v);
        return int'($signed(v));
    endfunction

    function automatic int as_u(input logic [15:0] v);
        return int'({16'h0000, v});
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        int m_s;
        int m_u;
        int ax;
        int work;
        int gate_sel;
        logic [15:0] m;
        logic rise;
        logic tick;
        logic [CNT_W-1:0] cnt_inc;
        m_s = 0;
        m_u = 0;
        ax = 0;
        work = 0;
        gate_sel = 0;
        m = 16'h0000;
        rise = 1'b0;
        tick = 1'b0;
        cnt_inc = '0;
        next_s = s;

        // Bus slave: ack one cycle after the request, drop next cycle
        next_s.ack = I_WB_CYC && I_WB_STB && !s.ack;
        if (I_WB_CYC && I_WB_STB && !s.ack) begin
            if (I_WB_ADR == ADR_CTRL) begin
                next_s.rdat = {29'h0000_0000, s.ctrl};
            end else if (I_WB_ADR == ADR_FREQ_ON) begin
                next_s.rdat = {16'h0000, s.freq_on};
            end else if (I_WB_ADR == ADR_FREQ_OFF) begin
                next_s.rdat = {16'h0000, s.freq_off};
            end else if (I_WB_ADR == ADR_GATE) begin
                next_s.rdat = {16'h0000, s.gate};
            end else if (I_WB_ADR == ADR_GAIN) begin
                next_s.rdat = 32'(as_s(s.gain));
            end else if (I_WB_ADR == ADR_OFFSET) begin
                next_s.rdat = 32'(as_s(s.offset));
            end else if (I_WB_ADR == ADR_ATRIG_ON) begin
                next_s.rdat = 32'(as_s(s.a_on));
            end else if (I_WB_ADR == ADR_ATRIG_OFF) begin
                next_s.rdat = 32'(as_s(s.a_off));
            end else if (I_WB_ADR == ADR_DIFF_ON) begin
                next_s.rdat = 32'(as_s(s.d_on));
            end else if (I_WB_ADR == ADR_DIFF_DELTA) begin
                next_s.rdat = 32'(as_s(s.d_delta));
            end else if (I_WB_ADR == ADR_DECIMALS) begin
                next_s.rdat = {30'h0000_0000, s.decimals};
            end else if (I_WB_ADR == ADR_STATUS) begin
                next_s.rdat = {29'h0000_0000, diff_q, atrig_q, freq_q};
            end else if (I_WB_ADR == ADR_MEASURED) begin
                next_s.rdat = 32'(s.measured);
            end else if (I_WB_ADR == ADR_WORKING) begin
                next_s.rdat = 32'(int'(s.working));
            end else begin
                next_s.rdat = 32'h0000_0000;
            end
        end

        // Writes take effect at the edge where ack is seen high
        if (I_WB_CYC && I_WB_STB && I_WB_WE && s.ack) begin
            if (I_WB_ADR == ADR_CTRL) begin
                if (I_WB_SEL[0]) begin
                    next_s.ctrl = I_WB_DAT[2:0];
                end
            end else if (I_WB_ADR == ADR_FREQ_ON) begin
                m = merge16(s.freq_on, I_WB_DAT, I_WB_SEL);
                next_s.freq_on = 16'(clamp(as_u(m), 0, FREQ_THR_MAX));
            end else if (I_WB_ADR == ADR_FREQ_OFF) begin
                m = merge16(s.freq_off, I_WB_DAT, I_WB_SEL);
                next_s.freq_off = 16'(clamp(as_u(m), 0, FREQ_THR_MAX));
            end else if (I_WB_ADR == ADR_GATE) begin
                m = merge16(s.gate, I_WB_DAT, I_WB_SEL);
                next_s.gate = 16'(clamp(as_u(m), GATE_MIN, GATE_MAX));
            end else if (I_WB_ADR == ADR_GAIN) begin
                m = merge16(s.gain, I_WB_DAT, I_WB_SEL);
                next_s.gain = 16'(clamp(as_s(m), -GAIN_LIM, GAIN_LIM));
            end else if (I_WB_ADR == ADR_OFFSET) begin
                m = merge16(s.offset, I_WB_DAT, I_WB_SEL);
                next_s.offset = 16'(clamp(as_s(m), -OFFSET_LIM, OFFSET_LIM));
            end else if (I_WB_ADR == ADR_ATRIG_ON) begin
                m = merge16(s.a_on, I_WB_DAT, I_WB_SEL);
                next_s.a_on = 16'(clamp(as_s(m), -THR_LIM, THR_LIM));
            end else if (I_WB_ADR == ADR_ATRIG_OFF) begin
                m = merge16(s.a_off, I_WB_DAT, I_WB_SEL);
                next_s.a_off = 16'(clamp(as_s(m), -THR_LIM, THR_LIM));
            end else if (I_WB_ADR == ADR_DIFF_ON) begin
                m = merge16(s.d_on, I_WB_DAT, I_WB_SEL);
                next_s.d_on = 16'(clamp(as_s(m), -THR_LIM, THR_LIM));
            end else if (I_WB_ADR == ADR_DIFF_DELTA) begin
                m = merge16(s.d_delta, I_WB_DAT, I_WB_SEL);
                next_s.d_delta = 16'(clamp(as_s(m), -THR_LIM, THR_LIM));
            end else if (I_WB_ADR == ADR_DECIMALS) begin
                if (I_WB_SEL[0]) begin
                    next_s.decimals = I_WB_DAT[1:0];
                end
            end
        end

        // gate from another block, kept in range
        if (s.ctrl[CTRL_GATE_EXT]) begin
            gate_sel = clamp(as_s(I_EXT_GATE), GATE_MIN, GATE_MAX);
        end else begin
            gate_sel = as_u(s.gate);
        end

        // one sample per cycle: pulse input must be far slower than the clock
        rise = I_PULSE && !s.pulse_prev;
        next_s.pulse_prev = I_PULSE;
        // Saturate so that a flood of pulses never wraps to a small count
        cnt_inc = (&s.pulse_cnt) ? s.pulse_cnt : s.pulse_cnt + CNT_W'(rise);
        next_s.freq_eval = 1'b0;

        if (!s.ctrl[CTRL_FREQ_EN]) begin
            next_s.tick_cnt = '0;
            next_s.centi_cnt = 16'h0000;
            next_s.pulse_cnt = '0;
            next_s.cur_gate = 16'(gate_sel);
        end else begin
            tick = (s.tick_cnt == TW'(TICK_CYCLES - 1));
            next_s.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);
            next_s.pulse_cnt = cnt_inc;
            if (tick) begin
                // gate counted in hundredths of a second
                if (s.centi_cnt == s.cur_gate - 16'h0001) begin
                    // latch total once per completed gate
                    next_s.measured = cnt_inc;
                    next_s.freq_eval = 1'b1;
                    // fresh count for the next gate
                    next_s.pulse_cnt = '0;
                    next_s.centi_cnt = 16'h0000;
                    // New gate only takes effect at an interval boundary
                    next_s.cur_gate = 16'(gate_sel);
                end else begin
                    next_s.centi_cnt = s.centi_cnt + 16'h0001;
                end
            end
        end

        ax = clamp(int'({22'h00_0000, I_ANALOG_OPERAND}), 0, ANALOG_MAX);
        // scaled integer, gain in hundredths, truncated
        work = (ax * as_s(s.gain)) / GAIN_SCALE + as_s(s.offset);
        next_s.working = 18'(work);
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.freq_on <= FREQ_ON_RST;
            s.freq_off <= FREQ_OFF_RST;
            s.gate <= GATE_RST;
            s.cur_gate <= GATE_RST;
            s.gain <= GAIN_RST;
            s.offset <= SIGNED_RST;
            s.a_on <= SIGNED_RST;
            s.a_off <= SIGNED_RST;
            s.d_on <= SIGNED_RST;
            s.d_delta <= SIGNED_RST;
            s.decimals <= DECIMALS_RST;
        end else if (I_CE) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Threshold switches
    logic signed [CW-1:0] f_val;
    logic signed [CW-1:0] f_on;
    logic signed [CW-1:0] f_off;
    logic signed [CW-1:0] a_val;
    logic signed [CW-1:0] a_on_sel;
    logic signed [CW-1:0] a_off_sel;
    logic signed [CW-1:0] d_on;
    logic signed [CW-1:0] d_off;

    assign f_val = CW'({1'b0, s.measured});
    assign f_on = CW'({1'b0, s.freq_on});
    assign f_off = CW'({1'b0, s.freq_off});
    assign a_val = CW'(s.working);
    assign a_on_sel = s.ctrl[CTRL_THR_EXT] ? CW'(clamp(as_s(I_EXT_ON), -THR_LIM, THR_LIM)) : CW'(s.a_on);
    assign a_off_sel = s.ctrl[CTRL_THR_EXT] ? CW'(clamp(as_s(I_EXT_OFF), -THR_LIM, THR_LIM)) : CW'(s.a_off);
    assign d_on = CW'(s.d_on);
    // off equals on plus signed delta
    assign d_off = CW'(s.d_on) + CW'(s.d_delta);

    ttu_thresh #(.W(CW)) u_freq (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_eval(s.freq_eval),
        .i_value(f_val),
        .i_on(f_on),
        .i_off(f_off),
        .o_q(freq_q)
    );

    ttu_thresh #(.W(CW)) u_atrig (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_eval(1'b1),
        .i_value(a_val),
        .i_on(a_on_sel),
        .i_off(a_off_sel),
        .o_q(atrig_q)
    );

    ttu_thresh #(.W(CW)) u_diff (
        .i_clk(I_CORE_CLK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_eval(1'b1),
        .i_value(a_val),
        .i_on(d_on),
        .i_off(d_off),
        .o_q(diff_q)
    );

    assign O_WB_DAT = s.rdat;
    assign O_WB_ACK = s.ack;
    assign O_FREQ_Q = freq_q;
    assign O_ATRIG_Q = atrig_q;
    assign O_DIFF_Q = diff_q;
    assign O_MEASURED = s.measured;
    assign O_WORKING = s.working;

endmodule

/* File: test/ttu_checker.sv */
// Port-level assertions for the threshold trigger unit
`timescale 1ns/1ps
module ttu_checker #(
    parameter int TICK_CYCLES = 2,
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Register bus
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    // Function signals
    input wire logic signed [15:0] I_EXT_ON,
    input wire logic signed [15:0] I_EXT_OFF,
    input wire logic O_FREQ_Q,
    input wire logic O_ATRIG_Q,
    input wire logic O_DIFF_Q,
    input wire logic [CNT_W-1:0] O_MEASURED,
    input wire logic signed [17:0] O_WORKING
);
    // Shortest legal gate is five hundredths, so updates never come closer
    localparam int MIN_GAP = 5 * TICK_CYCLES - 1;
    logic [15:0] m_gap;
    logic [15:0] q_gap;
    logic [CNT_W-1:0] m_prev;
    logic q_prev;

    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);

    // ========
    // Cycles since the last output update
    always_ff @(posedge I_CORE_CLK) begin
        m_prev <= O_MEASURED;
        q_prev <= O_FREQ_Q;
        if (!I_RSTN || O_MEASURED != m_prev) begin
            m_gap <= 16'h0000;
        end else if (m_gap != 16'hFFFF) begin
            m_gap <= m_gap + 16'h0001;
        end
        if (!I_RSTN || O_FREQ_Q != q_prev) begin
            q_gap <= 16'h0000;
        end else if (q_gap != 16'hFFFF) begin
            q_gap <= q_gap + 16'h0001;
        end
    end

    // ========
    // Bus and trigger properties
    chk_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK && I_CE |=> O_WB_ACK)
        else $error("ack missing after request");
    chk_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack held too long");
    chk_ack_cause: assert property ($rose(O_WB_ACK) |-> $past(I_WB_STB))
        else $error("ack without request");
    chk_dat_hold: assert property ($changed(O_WB_DAT) |-> O_WB_ACK)
        else $error("read data moved outside a transfer");
    chk_work_range: assert property (O_WORKING >= -20000 && O_WORKING <= 20000)
        else $error("working value out of range");
    chk_meas_gate: assert property ($changed(O_MEASURED) |-> m_gap >= MIN_GAP)
        else $error("measured value updated inside a gate");
    chk_freq_gate: assert property ($changed(O_FREQ_Q) |-> q_gap >= MIN_GAP)
        else $error("frequency output moved inside a gate");
    chk_atrig_hold: assert property (!O_WB_ACK && !$past(O_WB_ACK) && !$past(O_WB_ACK, 2)
        && O_WORKING == $past(O_WORKING) && O_WORKING == $past(O_WORKING, 2)
        && $past(I_EXT_ON) == $past(I_EXT_ON, 2) && $past(I_EXT_OFF) == $past(I_EXT_OFF, 2) |-> $stable(O_ATRIG_Q))
        else $error("analog output moved with steady inputs");
    chk_diff_hold: assert property (!O_WB_ACK && !$past(O_WB_ACK) && !$past(O_WB_ACK, 2)
        && O_WORKING == $past(O_WORKING) && O_WORKING == $past(O_WORKING, 2) |-> $stable(O_DIFF_Q))
        else $error("differential output moved with steady inputs");
endmodule

/* File: test/ttu_pulse_src.sv */
// Pulse source standing in for a counting input terminal
`timescale 1ns/1ps
module ttu_pulse_src (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [7:0] i_half,
    // Pulse out
    output logic o_pulse
);
    logic [7:0] cnt = 8'h00;

    // slow source: one edge per i_half clocks
    always @(posedge i_clk) begin
        if (!i_en) begin
            cnt <= 8'h00;
            o_pulse <= 1'b0;
        end else if (cnt + 8'h01 >= i_half) begin
            cnt <= 8'h00;
            o_pulse <= !o_pulse;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

/* File: test/ttu_tb_top.sv */
// Self-checking bench for the threshold trigger unit
`timescale 1ns/1ps
module ttu_tb_top
    import ttu_pkg::*;
;
    // Short tick makes each hundredth of a gate two cycles
    localparam int TICK = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] rdat;
    logic [9:0] ax = 10'h000;
    logic signed [15:0] ext_gate = 16'h000C;
    logic signed [15:0] ext_on = 16'hF448;
    logic signed [15:0] ext_off = 16'hF830;
    logic [7:0] half = 8'h01;
    logic pulse;
    logic ack;
    logic fq;
    logic aq;
    logic dq;
    logic [19:0] meas;
    logic signed [17:0] work;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] cl_a [8] = '{ADR_FREQ_ON, ADR_GAIN, ADR_OFFSET, ADR_ATRIG_ON, ADR_DIFF_DELTA, ADR_GATE,
        ADR_GATE, ADR_DECIMALS};
    logic [31:0] cl_w [8] = '{32'h0000_FFFF, 32'h0000_07D0, 32'h0000_B1E0, 32'h0000_7530,
        32'h0000_8AD0, 32'h0000_2710, 32'h0000_0002, 32'h0000_0003};
    logic [31:0] cl_e [8] = '{32'h0000_270F, 32'h0000_03E8, 32'hFFFF_D8F0, 32'h0000_4E20,
        32'hFFFF_B1E0, 32'h0000_270F, 32'h0000_0005, 32'h0000_0003};
    logic [7:0] rs_a [8] = '{ADR_CTRL, ADR_FREQ_ON, ADR_GATE, ADR_GAIN, ADR_OFFSET, ADR_DECIMALS,
        ADR_STATUS, 8'h3C};
    logic [15:0] rs_e [8] = '{16'h0001, 16'h0000, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] fon [5] = '{16'h0004, 16'h0005, 16'h0009, 16'h0005, 16'h0006};
    logic [15:0] foff [5] = '{16'h0002, 16'h0002, 16'h0005, 16'h0006, 16'h0009};
    logic [4:0] fexp = 5'b0_1011;
    logic [7:0] cf_a [6] = '{ADR_GAIN, ADR_OFFSET, ADR_ATRIG_ON, ADR_ATRIG_OFF, ADR_DIFF_ON, ADR_DIFF_DELTA};
    logic [15:0] cf [12] = '{16'h0064, 16'h0000, 16'h01F4, 16'h00C8, 16'h012C, 16'hFF9C,
        16'hFF06, 16'h0064, 16'hFC18, 16'hFCE0, 16'hFC18, 16'h00C8};
    logic [9:0] an_x [8] = '{10'h258, 10'h12C, 10'h0C8, 10'h190, 10'h190, 10'h168, 10'h1B8, 10'h3FF};
    logic [31:0] an_w [8] = '{32'h0000_0258, 32'h0000_012C, 32'h0000_00C8, 32'h0000_0190,
        32'hFFFF_FC7C, 32'hFFFF_FCE0, 32'hFFFF_FC18, 32'hFFFF_F6A0};
    logic [1:0] an_q [8] = '{2'h3, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h3, 2'h0};

    ttu_pulse_src src (.i_clk(clk), .i_en(rstn), .i_half(half), .o_pulse(pulse));

    ttu_top #(.TICK_CYCLES(TICK)) dut (
        .I_CORE_CLK(clk), .I_RSTN(rstn), .I_CE(1'b1),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_PULSE(pulse), .I_ANALOG_OPERAND(ax), .I_EXT_GATE(ext_gate), .I_EXT_ON(ext_on),
        .I_EXT_OFF(ext_off), .O_FREQ_Q(fq), .O_ATRIG_Q(aq), .O_DIFF_Q(dq),
        .O_MEASURED(meas), .O_WORKING(work)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end

    // ========
    // Bus access and comparison
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        // Only the bench timeout ends a wait for the answer
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        check("register", e, rd);
    endtask

    task automatic acase(input logic [9:0] x, input logic [31:0] w, input logic [1:0] q);
        ax <= x;
        repeat (4) @(posedge clk);
        check("working", w, 32'(work));
        check("trigger outs", {30'h0, q}, {30'h0, aq, dq});
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ========
    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wr(8'h3C, 32'h0000_1234);
        for (int i = 0; i < 8; i++) begin
            rc(rs_a[i], {16'h0000, rs_e[i]});
        end
        for (int i = 0; i < 8; i++) begin
            wr(cl_a[i], cl_w[i]);
            rc(cl_a[i], cl_e[i]);
        end
        // Old gate of one second must run out before the short one applies
        repeat (450) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            wr(ADR_FREQ_ON, {16'h0000, fon[i]});
            wr(ADR_FREQ_OFF, {16'h0000, foff[i]});
            repeat (30) @(posedge clk);
            check("measured", 32'h0000_0005, {12'h000, meas});
            check("freq out", {31'h0, fexp[i]}, {31'h0, fq});
        end
        half <= 8'h03;
        wr(ADR_CTRL, 32'h0000_0003);
        repeat (80) @(posedge clk);
        check("measured", 32'h0000_0004, {12'h000, meas});
        rc(ADR_MEASURED, 32'h0000_0004);
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 6; i++) begin
                wr(cf_a[i], {{16{cf[6*s+i][15]}}, cf[6*s+i]});
            end
            for (int i = 4 * s; i < 4 * s + 4; i++) begin
                acase(an_x[i], an_w[i], an_q[i]);
            end
        end
        wr(ADR_CTRL, 32'h0000_0005);
        acase(10'h3FF, 32'hFFFF_F6A0, 2'h2);
        rc(ADR_STATUS, 32'h0000_0002);
        rc(ADR_WORKING, 32'hFFFF_F6A0);
        // Disabled counter must hold the slow-source count, never reach the fast one
        half <= 8'h01;
        wr(ADR_CTRL, 32'h0000_0004);
        repeat (30) @(posedge clk);
        check("freq hold", 32'h0000_0000, {31'h0, meas == 20'h0_0005});
        results();
    end
endmodule

bind ttu_top ttu_checker #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_EXT_ON(I_EXT_ON), .I_EXT_OFF(I_EXT_OFF),
    .O_FREQ_Q(O_FREQ_Q), .O_ATRIG_Q(O_ATRIG_Q), .O_DIFF_Q(O_DIFF_Q), .O_MEASURED(O_MEASURED),
    .O_WORKING(O_WORKING)
);
